// ### design/page_map_pkg.sv
// Constants shared by the program page mapper and its page-select register
package page_map_pkg;
	localparam int PC_WIDTH = 12;
	localparam int OFFSET_WIDTH = 11;
	localparam int PAGE_WIDTH = 2;
	localparam int PHYS_WIDTH = 13;
	localparam int DATA_ADDR_WIDTH = 8;
	localparam int DATA_WIDTH = 8;
	localparam logic [7:0] PAGE_SELECT_ADDR = 8'hCA;
	localparam logic [1:0] STATIC_PAGE = 2'h1;
	localparam logic [1:0] PAGE_SELECT_RESET = 2'h1;
	localparam int UPPER_BIT = 11;
	localparam logic [11:0] RESET_VECTOR_ADDR = 12'hFFE;
	localparam logic [11:0] NMI_VECTOR_ADDR = 12'hFFC;
	localparam logic [11:0] IRQ_VECTOR_FIRST = 12'hFF0;
	localparam logic [11:0] IRQ_VECTOR_LAST = 12'hFF7;
	localparam logic [12:0] PHYS_RESET_VALUE = 13'h0000;
	typedef enum logic [1:0] {
		SEL_IDLE = 2'b01,
		SEL_WRITE = 2'b10
	} sel_state_e;
endpackage : page_map_pkg

// ### design/page_select_reg.sv
// Write-only page-select register on the core data bus
`timescale 1ns/1ps
module page_select_reg #(
	parameter int DW = 8
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic wr_en,
	input wire logic [DW-1:0] wr_data,
	output logic [1:0] page_q
);
	// Only bits 1-0 are kept; the upper bits are ignored
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			page_q <= page_map_pkg::PAGE_SELECT_RESET;
		end else if (wr_en) begin
			page_q <= wr_data[1:0];
		end
	end
endmodule : page_select_reg

// ### design/program_page_mapper.sv
// Program counter to physical program memory address translation
`timescale 1ns/1ps
// Summary of operation
// (RULE_01) Every fetch or operand access is addressed by a 12-bit program counter and translated.
// (RULE_02) Memory is four 2-Kbyte pages; page index above the low 11 bits forms the address.
// (RULE_03) With counter bit 11 low, the access goes to the page held in the page-select register.
// (RULE_04) With counter bit 11 high, the access always goes to the static page.
// (RULE_05) Selecting the static page through the low range reaches the same storage.
// (RULE_06) Reset, NMI and interrupt vectors sit at the top of the static page.
// (RULE_07) Software changes dynamic pages only from code running in the static page.
// (RULE_08) Bits 1-0 of the page-select register pick the page; upper bits are unused.
// (RULE_09) The page-select register is write-only at data address CAh.
// (RULE_10) A page-select write takes effect on the next fetch after the write completes.
module program_page_mapper #(
	parameter int PCW = page_map_pkg::PC_WIDTH,
	parameter int DW = page_map_pkg::DATA_WIDTH
) (
	input wire logic CLK_SYS,
	input wire logic RESETN,
	input wire logic FETCH_VALID,
	input wire logic [PCW-1:0] PROGRAM_COUNTER,
	input wire logic DATA_WR,
	input wire logic [page_map_pkg::DATA_ADDR_WIDTH-1:0] DATA_ADDR,
	input wire logic [DW-1:0] DATA_WDATA,
	output logic [page_map_pkg::PHYS_WIDTH-1:0] PHYS_ADDR,
	output logic PHYS_VALID,
	output logic STATIC_HIT,
	output logic VECTOR_HIT,
	output logic [1:0] CUR_PAGE
);
	logic page_wr;
	logic [1:0] page_select_bits;
	logic [1:0] page_sel;
	logic upper;
	logic in_irq_slots;
	logic in_nmi_slot;
	logic in_reset_slot;
	logic vector_slot;
	page_map_pkg::sel_state_e sel_q;
	page_map_pkg::sel_state_e sel_d;

	// Decode of the write-only register; reads have no decode at all
	assign page_wr = DATA_WR && (DATA_ADDR == page_map_pkg::PAGE_SELECT_ADDR); // [RULE_09]

	page_select_reg #(
		.DW(DW)
	) u_sel (
		.clk(CLK_SYS),
		.rst_n(RESETN),
		.wr_en(page_wr),
		.wr_data(DATA_WDATA), // [RULE_08]
		.page_q(page_select_bits)
	);

	// Tracks a write in flight so tooling can see when the new page lands
	always_comb begin
		sel_d = sel_q;
		case (sel_q)
			page_map_pkg::SEL_IDLE: begin
				if (page_wr) begin
					sel_d = page_map_pkg::SEL_WRITE;
				end
			end
			page_map_pkg::SEL_WRITE: begin
				if (!page_wr) begin
					sel_d = page_map_pkg::SEL_IDLE;
				end
			end
			default: sel_d = page_map_pkg::SEL_IDLE;
		endcase
	end

	always_ff @(posedge CLK_SYS) begin
		if (!RESETN) begin
			sel_q <= page_map_pkg::SEL_IDLE;
		end else begin
			sel_q <= sel_d;
		end
	end

	// Register value is used only after the write edge, so a fetch in the
	// write cycle still sees the old page
	assign upper = PROGRAM_COUNTER[page_map_pkg::UPPER_BIT]; // [RULE_01]
	assign page_sel = upper ? page_map_pkg::STATIC_PAGE : page_select_bits; // [RULE_03] [RULE_04] [RULE_10]

	// Vector slots decoded on the full counter; the reserved words between
	// the interrupt and NMI slots stay unflagged on purpose
	assign in_irq_slots = (PROGRAM_COUNTER >= page_map_pkg::IRQ_VECTOR_FIRST) &&
		(PROGRAM_COUNTER <= page_map_pkg::IRQ_VECTOR_LAST); // [RULE_06]
	assign in_nmi_slot = (PROGRAM_COUNTER >= page_map_pkg::NMI_VECTOR_ADDR) &&
		(PROGRAM_COUNTER < page_map_pkg::RESET_VECTOR_ADDR); // [RULE_06]
	assign in_reset_slot = (PROGRAM_COUNTER >= page_map_pkg::RESET_VECTOR_ADDR); // [RULE_06]
	assign vector_slot = upper && (in_irq_slots || in_nmi_slot || in_reset_slot);

	// Registered translation; one cycle of latency from request to address
	always_ff @(posedge CLK_SYS) begin
		if (!RESETN) begin
			PHYS_ADDR <= page_map_pkg::PHYS_RESET_VALUE;
			PHYS_VALID <= 1'b0;
			STATIC_HIT <= 1'b0;
			VECTOR_HIT <= 1'b0;
		end else begin
			PHYS_VALID <= FETCH_VALID;
			if (FETCH_VALID) begin
				// Same page index for both routes into the static page
				PHYS_ADDR <= {page_sel, PROGRAM_COUNTER[page_map_pkg::OFFSET_WIDTH-1:0]}; // [RULE_02] [RULE_05]
				STATIC_HIT <= (page_sel == page_map_pkg::STATIC_PAGE);
				// Vector area flag, reset/NMI/interrupt slots
				VECTOR_HIT <= vector_slot; // [RULE_06]
			end
		end
	end

	// Current page mirror for debug
	always_ff @(posedge CLK_SYS) begin
		if (!RESETN) begin
			CUR_PAGE <= page_map_pkg::PAGE_SELECT_RESET;
		end else begin
			CUR_PAGE <= page_select_bits;
		end
	end

	// Software discipline on page changes is not enforced here [RULE_07]

	sequence s_upper_fetch;
		FETCH_VALID && PROGRAM_COUNTER[11];
	endsequence

	sequence s_lower_fetch;
		FETCH_VALID && !PROGRAM_COUNTER[11];
	endsequence

	sequence s_page_write;
		DATA_WR && DATA_ADDR == page_map_pkg::PAGE_SELECT_ADDR;
	endsequence

	chk_upper_static: assert property (@(posedge CLK_SYS) disable iff (!RESETN) // [RULE_04]
		s_upper_fetch |=> PHYS_ADDR[12:11] == 2'h1)
		else $error("Upper range did not reach static page");

	chk_lower_dyn: assert property (@(posedge CLK_SYS) disable iff (!RESETN) // [RULE_03]
		s_lower_fetch |=> PHYS_ADDR[12:11] == $past(page_select_bits))
		else $error("Lower range page mismatch");

	chk_offset_kept: assert property (@(posedge CLK_SYS) disable iff (!RESETN) // [RULE_02]
		FETCH_VALID |=> PHYS_ADDR[10:0] == $past(PROGRAM_COUNTER[10:0]))
		else $error("Offset bits altered");

	chk_write_takes: assert property (@(posedge CLK_SYS) disable iff (!RESETN) // [RULE_10]
		s_page_write ##1 s_lower_fetch |=>
		PHYS_ADDR[12:11] == $past(DATA_WDATA[1:0], 2))
		else $error("Page write not seen by next fetch");

	chk_reg_decode: assert property (@(posedge CLK_SYS) disable iff (!RESETN) // [RULE_09]
		!page_wr |=> $stable(page_select_bits))
		else $error("Page select changed without write");

	chk_bits_only: assert property (@(posedge CLK_SYS) disable iff (!RESETN) // [RULE_08]
		page_wr |=> page_select_bits == $past(DATA_WDATA[1:0]))
		else $error("Page select bits wrong");

	chk_static_same: assert property (@(posedge CLK_SYS) disable iff (!RESETN) // [RULE_05]
		FETCH_VALID && page_select_bits == 2'h1 |=> STATIC_HIT)
		else $error("Static page alias not flagged");

	chk_valid_follows: assert property (@(posedge CLK_SYS) disable iff (!RESETN) // [RULE_01]
		FETCH_VALID |=> PHYS_VALID)
		else $error("Fetch not translated");

	chk_vector_flag: assert property (@(posedge CLK_SYS) disable iff (!RESETN) // [RULE_06]
		FETCH_VALID && PROGRAM_COUNTER == 12'hFFE |=> VECTOR_HIT && PHYS_ADDR == 13'h0FFE)
		else $error("Reset vector not mapped");

	// Checks below also read internal signals such as sel_q, page_select_bits and page_wr, not only the ports
	chk_sel_track: assert property (@(posedge CLK_SYS) disable iff (!RESETN) // [RULE_10]
		sel_q == page_map_pkg::SEL_WRITE |-> page_select_bits == $past(DATA_WDATA[1:0]))
		else $error("Write tracker out of step with register");

	chk_valid_drops: assert property (@(posedge CLK_SYS) disable iff (!RESETN) // [RULE_01]
		!FETCH_VALID |=> !PHYS_VALID)
		else $error("Valid without a fetch");

	chk_addr_holds: assert property (@(posedge CLK_SYS) disable iff (!RESETN) // [RULE_02]
		!FETCH_VALID |=> $stable(PHYS_ADDR))
		else $error("Address moved without a fetch");

	chk_cur_mirror: assert property (@(posedge CLK_SYS) disable iff (!RESETN) // [RULE_08]
		1'b1 |=> CUR_PAGE == $past(page_select_bits))
		else $error("Page mirror wrong");

	chk_same_cycle: assert property (@(posedge CLK_SYS) disable iff (!RESETN) // [RULE_10]
		page_wr && FETCH_VALID && !PROGRAM_COUNTER[11] |=>
		PHYS_ADDR[12:11] == $past(page_select_bits))
		else $error("Fetch in write cycle saw new page");

	chk_other_addr: assert property (@(posedge CLK_SYS) disable iff (!RESETN) // [RULE_09]
		DATA_WR && DATA_ADDR != page_map_pkg::PAGE_SELECT_ADDR |=> $stable(page_select_bits))
		else $error("Foreign write changed page select");

	chk_irq_flag: assert property (@(posedge CLK_SYS) disable iff (!RESETN) // [RULE_06]
		FETCH_VALID && PROGRAM_COUNTER[11:3] == 9'h1FE |=> VECTOR_HIT)
		else $error("Interrupt vector not flagged");

	chk_nmi_flag: assert property (@(posedge CLK_SYS) disable iff (!RESETN) // [RULE_06]
		FETCH_VALID && PROGRAM_COUNTER[11:1] == 11'h7FE |=> VECTOR_HIT)
		else $error("NMI vector not flagged");

	chk_reserved_clear: assert property (@(posedge CLK_SYS) disable iff (!RESETN) // [RULE_06]
		FETCH_VALID && PROGRAM_COUNTER[11:2] == 10'h3FE |=> !VECTOR_HIT)
		else $error("Reserved words flagged as vector");

	chk_lower_novec: assert property (@(posedge CLK_SYS) disable iff (!RESETN) // [RULE_06]
		s_lower_fetch |=> !VECTOR_HIT)
		else $error("Lower range flagged as vector");

	chk_reset_quiet: assert property (@(posedge CLK_SYS) // [RULE_01]
		!RESETN |=> !PHYS_VALID && !STATIC_HIT && !VECTOR_HIT &&
		PHYS_ADDR == page_map_pkg::PHYS_RESET_VALUE)
		else $error("Outputs not cleared by reset");

	chk_static_flag: assert property (@(posedge CLK_SYS) disable iff (!RESETN) // [RULE_04]
		s_upper_fetch |=> STATIC_HIT)
		else $error("Upper fetch not flagged static");

	chk_dyn_flag: assert property (@(posedge CLK_SYS) disable iff (!RESETN) // [RULE_03]
		FETCH_VALID && !PROGRAM_COUNTER[11] && page_select_bits != page_map_pkg::STATIC_PAGE
		|=> !STATIC_HIT)
		else $error("Dynamic page flagged static");
endmodule : program_page_mapper

// ### verification/fetch_core_model.sv
// Core fetch and data-write side facing the page mapper
`timescale 1ns/1ps
module fetch_core_model (
	input wire logic clk,
	output logic fetch_valid,
	output logic [11:0] pc,
	output logic data_wr,
	output logic [7:0] data_addr,
	output logic [7:0] wdata
);
	// Idle bus until the first request
	initial begin
		fetch_valid = 1'b0;
		pc = 12'h000;
		data_wr = 1'b0;
		data_addr = 8'h00;
		wdata = 8'h00;
	end
	// One bus cycle, launched on the falling edge so it is stable when sampled
	task step(input logic f, input logic [11:0] p, input logic w, input logic [7:0] a,
		input logic [7:0] d);
		@(negedge clk);
		fetch_valid = f;
		pc = p;
		data_wr = w;
		data_addr = a;
		wdata = d;
	endtask : step
endmodule : fetch_core_model

// ### verification/program_page_mapper_tb.sv
// Self-checking bench for the program page mapper
`timescale 1ns/1ps
module program_page_mapper_tb;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic fv, dw, pv, sh, vh;
	logic [11:0] pc;
	logic [7:0] da, dd;
	logic [12:0] phys;
	logic [1:0] cur;
	int mismatches = 0;
	int total_checks = 0;
	int page_m = 1;
	int cycles = 0;
	logic [12:0] exp_q[$];
	// 40 MHz clock
	always #12.5 clk = ~clk;
	// Ceiling well above the planned run so a hang still ends in a report
	always @(posedge clk) begin
		cycles++;
		if (cycles == 1000) begin
			mismatches++;
			results();
		end
	end
	program_page_mapper i_dut (.CLK_SYS(clk), .RESETN(rstn), .FETCH_VALID(fv),
		.PROGRAM_COUNTER(pc), .DATA_WR(dw), .DATA_ADDR(da), .DATA_WDATA(dd),
		.PHYS_ADDR(phys), .PHYS_VALID(pv), .STATIC_HIT(sh), .VECTOR_HIT(vh), .CUR_PAGE(cur));
	fetch_core_model i_core (.clk(clk), .fetch_valid(fv), .pc(pc), .data_wr(dw),
		.data_addr(da), .wdata(dd));
	task bad(input logic [12:0] g, input logic [12:0] e);
		mismatches++;
		$display("unexpected at %0t: got %h expected %h", $time, g, e);
	endtask : bad
	task cmp_addr(input logic [12:0] g, input logic [12:0] e);
		total_checks++;
		if (g !== e) bad(g, e);
	endtask : cmp_addr
	task cmp_flags(input logic [4:0] g, input logic [4:0] e);
		total_checks++;
		if (g !== e) bad({8'h00, g}, {8'h00, e});
	endtask : cmp_flags
	// Data write only; the model page follows writes that hit the select address
	task write(input logic [7:0] a, input logic [7:0] d);
		i_core.step(1'b0, 12'h000, 1'b1, a, d);
		if (a == 8'hCA) page_m = d[1:0];
	endtask : write
	// One fetch, with an optional write in the same cycle, then its answer checked
	task fetch(input logic [11:0] p, input logic w, input logic [7:0] d);
		logic [1:0] old;
		logic [1:0] pg;
		logic vec;
		old = 2'(page_m);
		pg = p[11] ? 2'h1 : old;
		vec = p[11] && (p[10:3] == 8'hFE || p[10:2] == 9'h1FF);
		exp_q.push_back({pg, p[10:0]});
		i_core.step(1'b1, p, w, 8'hCA, d);
		if (w) page_m = d[1:0];
		i_core.step(1'b0, p, 1'b0, 8'hCA, d);
		cmp_addr(phys, exp_q.pop_front());
		cmp_flags({pv, sh, vh, cur}, {1'b1, pg == 2'h1, vec, old});
	endtask : fetch
	task results;
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : results
	initial begin
		void'($urandom(32'h687f12dd));
		repeat (5) @(negedge clk);
		rstn = 1'b1;
		cmp_addr(phys, 13'h0000);
		cmp_flags({pv, sh, vh, cur}, 5'h01);
		$display("reset test done");
		// Every select code, junk in the unused bits, and a hop through static
		for (int i = 0; i < 4; i++) begin
			write(8'hCA, {6'($urandom), 2'(i)});
			fetch(12'($urandom) & 12'h7FF, 1'b0, 8'h00);
			fetch(12'($urandom) | 12'h800, 1'b0, 8'h00);
		end
		$display("page code test done");
		write(8'hCA, 8'h01);
		write(8'hCB, 8'h00);
		fetch(12'h345, 1'b1, 8'h02);
		fetch(12'hA00, 1'b1, 8'h01);
		fetch(12'h7FF, 1'b0, 8'h00);
		fetch(12'hFFF, 1'b0, 8'h00);
		$display("ordering test done");
		for (int v = 12'hFEE; v <= 12'hFFF; v++) fetch(12'(v), 1'b0, 8'h00);
		$display("vector test done");
		repeat (30) begin
			if ($urandom % 3 == 0) begin
				fetch(12'($urandom) | 12'h800, 1'b0, 8'h00);
				write(8'hCA, 8'($urandom));
			end
			fetch(12'($urandom), 1'b0, 8'h00);
		end
		$display("random test done");
		results();
	end
endmodule : program_page_mapper_tb
